// *** hdl/iss_cond.sv ***
// bus condition finder: scl edges, start and stop from synchronised lines
module iss_cond (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // synchronised bus lines
    input  wire logic scl_s,
    input  wire logic sda_s,
    // one-cycle events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);
    logic scl_d_r; // previous scl sample
    logic sda_d_r; // previous sda sample

    // history of both lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // start and stop need scl high before and after the sda edge
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
endmodule

// *** hdl/iss_i2c_slave.sv ***
// i2c slave byte engine with apb register file
// What this block does
// - own 7-bit address sits in bits 7..1
// - address bit 0 is plain storage, unused
// - address register shared with spi second control
// - sda fall with scl high sets busy
// - seven address bits msb first, match flags
// - eighth bit stored as master read flag
// - match drives ack low on ninth clock
// - one interrupt for match and byte; the timeout cause never fires
// - hold scl low until software services
// - data bytes eight bits, msb first
// - receiver drives ack_to_send on ninth clock
// - master nack makes transmitter release sda
// - ninth clock level stored, transmit only on ack
// - bytes pass through the shared data buffer
// - byte done low in transfer, set after
// - stop clears bus busy
module iss_i2c_slave (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // i2c pins, open drain
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // serial interrupt, one-cycle pulse
    output logic             serial_irq
);
    // apb state
    logic        pready_r;       // access completes in the cycle this is high
    logic [31:0] prdata_r;       // read data captured in the wait cycle
    logic        pslverr_r;      // unmapped address
    logic [31:0] rd_mux;         // read data of the addressed register
    logic        hit;            // address decodes to a register
    logic        wr_acc;         // write takes effect this edge
    logic        rd_acc;         // read completes this edge
    // configuration
    logic [2:0]  mode_r;         // interface_mode_select
    logic [1:0]  deb_r;          // debounce select, stored only
    logic        en_r;           // interface_enable
    logic [7:0]  own_addr_r;     // own_slave_address
    logic        irq_en_r;       // serial_irq_enable
    logic        tof_r;          // timeout_flag
    logic        htx_r;          // transmit_select
    logic        ack_to_send_r;         // ack_to_send
    logic        wake_r;         // address match wake enable, stored only
    // engine state
    iss_pkg::iss_state_t st_r;   // byte engine state
    logic [3:0]  cnt_r;          // scl rises counted in the byte
    logic [7:0]  sh_r;           // shift register
    logic [7:0]  dbuf_r;         // serial_data_buffer
    logic        ack_on_r;       // ninth clock low phase entered
    logic        hcf_r;          // byte_done_flag
    logic        address_match_flag_r;         // address_match_flag
    logic        hbb_r;          // bus_busy_flag
    logic        srw_r;          // master_read_flag
    logic        ack_received_flag_r;         // ack_received_flag
    logic        sda_oe_r;       // pulls sda low
    logic        scl_oe_r;       // stretches scl low
    logic        ev_r;           // interrupt cause seen
    logic        irq_r;          // gated interrupt pulse
    // bus side
    logic        scl_s;
    logic        sda_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        active;
    logic        tx_go;
    logic        rx_go;

    // pins pass two flip-flops before any logic reads them
    iss_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .async_i ({scl_i, sda_i}),
        .sync_o  ({scl_s, sda_s})
    );

    iss_cond u_cond (
        .pclk      (pclk),
        .presetn   (presetn),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    assign active = en_r && (mode_r == iss_pkg::MODE_I2C);
    assign wr_acc = psel & penable & pready_r & pwrite;
    assign rd_acc = psel & penable & pready_r & ~pwrite;
    // software service of a held bus: write in transmit, dummy read in receive
    assign tx_go  = wr_acc && (paddr == iss_pkg::OFS_DATA_BUF) && htx_r;
    assign rx_go  = rd_acc && (paddr == iss_pkg::OFS_DATA_BUF) && !htx_r;

    // read decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            iss_pkg::OFS_MODE_CTRL: begin
                rd_mux[iss_pkg::MODE_MSB:iss_pkg::MODE_LSB] = mode_r;
                rd_mux[iss_pkg::DEB_MSB:iss_pkg::DEB_LSB]   = deb_r;
                rd_mux[iss_pkg::EN_BIT]                     = en_r;
            end
            iss_pkg::OFS_STATUS_CTRL: begin
                rd_mux[7:0] = {hcf_r, address_match_flag_r, hbb_r, htx_r, ack_to_send_r, srw_r, wake_r, ack_received_flag_r};
            end
            iss_pkg::OFS_DATA_BUF: rd_mux[7:0] = dbuf_r;
            iss_pkg::OFS_OWN_ADDR: rd_mux[7:0] = own_addr_r;
            iss_pkg::OFS_IRQ_CTRL: begin
                rd_mux[iss_pkg::IRQEN_BIT] = irq_en_r;
                rd_mux[iss_pkg::TOF_BIT]   = tof_r;
            end
            default: hit = 1'b0;
        endcase
    end

    // apb handshake: one wait cycle, data and error registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel & penable & ~pready_r;
            if (psel & penable & ~pready_r) begin
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr_r <= ~hit;
            end else begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // software-owned configuration bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r     <= iss_pkg::MODE_RST;
            deb_r      <= 2'h0;
            en_r       <= 1'b0;
            own_addr_r <= iss_pkg::BYTE_RST;
            irq_en_r   <= 1'b0;
            tof_r      <= 1'b0;
            htx_r      <= 1'b0;
            ack_to_send_r     <= 1'b0;
            wake_r     <= 1'b0;
        end else if (wr_acc) begin
            case (paddr)
                iss_pkg::OFS_MODE_CTRL: begin
                    mode_r <= pwdata[iss_pkg::MODE_MSB:iss_pkg::MODE_LSB];
                    deb_r  <= pwdata[iss_pkg::DEB_MSB:iss_pkg::DEB_LSB];
                    en_r   <= pwdata[iss_pkg::EN_BIT];
                end
                iss_pkg::OFS_STATUS_CTRL: begin
                    htx_r  <= pwdata[iss_pkg::HTX_BIT];
                    ack_to_send_r <= pwdata[iss_pkg::ACK_TO_SEND_BIT];
                    wake_r <= pwdata[iss_pkg::WAKE_BIT];
                end
                // one storage for both modes, read back the same in every mode
                iss_pkg::OFS_OWN_ADDR: own_addr_r <= pwdata[7:0];
                iss_pkg::OFS_IRQ_CTRL: begin
                    irq_en_r <= pwdata[iss_pkg::IRQEN_BIT];
                    tof_r    <= pwdata[iss_pkg::TOF_BIT];
                end
                default: ;
            endcase
        end
    end

    // byte engine; flags sit at their defaults while disabled, so enabling
    // starts from a clean status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= iss_pkg::ISS_IDLE;
            cnt_r    <= 4'h0;
            sh_r     <= iss_pkg::BYTE_RST;
            dbuf_r   <= iss_pkg::BYTE_RST;
            ack_on_r <= 1'b0;
            hcf_r    <= iss_pkg::HCF_RST;
            address_match_flag_r   <= 1'b0;
            hbb_r    <= 1'b0;
            srw_r    <= 1'b0;
            ack_received_flag_r   <= iss_pkg::ACK_RECEIVED_FLAG_RST;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            ev_r     <= 1'b0;
        end else begin
            ev_r <= 1'b0;
            if (wr_acc && paddr == iss_pkg::OFS_DATA_BUF) begin
                dbuf_r <= pwdata[7:0];
            end
            if (!active) begin
                st_r     <= iss_pkg::ISS_IDLE;
                hcf_r    <= iss_pkg::HCF_RST;
                address_match_flag_r   <= 1'b0;
                hbb_r    <= 1'b0;
                srw_r    <= 1'b0;
                ack_received_flag_r   <= iss_pkg::ACK_RECEIVED_FLAG_RST;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
            end else if (stop_det) begin
                hbb_r    <= 1'b0;
                st_r     <= iss_pkg::ISS_IDLE;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
            end else if (start_det) begin
                hbb_r    <= 1'b1;
                address_match_flag_r   <= 1'b0;
                cnt_r    <= 4'h0;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
                st_r     <= iss_pkg::ISS_ADDR;
            end else begin
                case (st_r)
                    iss_pkg::ISS_ADDR: if (scl_rise) begin
                        // sda sampled on scl rising edge, msb first
                        sh_r  <= {sh_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == iss_pkg::CNT_LAST) begin
                            if (sh_r[6:0] == own_addr_r[7:1]) begin
                                address_match_flag_r   <= 1'b1;
                                srw_r    <= sda_s;
                                ev_r     <= 1'b1;
                                ack_on_r <= 1'b0;
                                st_r     <= iss_pkg::ISS_ACKA;
                            end else begin
                                st_r <= iss_pkg::ISS_IGN;
                            end
                        end
                    end
                    // ninth clock: drive on the fall before it, release and
                    // stretch on the fall after it
                    iss_pkg::ISS_ACKA, iss_pkg::ISS_ACKR: if (scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_r <= 1'b1;
                            sda_oe_r <= (st_r == iss_pkg::ISS_ACKA) ? 1'b1 : !ack_to_send_r;
                        end else begin
                            ack_on_r <= 1'b0;
                            sda_oe_r <= 1'b0;
                            scl_oe_r <= 1'b1;
                            st_r     <= iss_pkg::ISS_HOLD;
                        end
                    end
                    iss_pkg::ISS_HOLD: begin
                        if (tx_go) begin
                            sh_r     <= pwdata[7:0];
                            sda_oe_r <= !pwdata[7];
                            cnt_r    <= 4'h0;
                            hcf_r    <= 1'b0;
                            address_match_flag_r   <= 1'b0;
                            scl_oe_r <= 1'b0;
                            st_r     <= iss_pkg::ISS_TX;
                        end else if (rx_go) begin
                            cnt_r    <= 4'h0;
                            hcf_r    <= 1'b0;
                            address_match_flag_r   <= 1'b0;
                            scl_oe_r <= 1'b0;
                            st_r     <= iss_pkg::ISS_RX;
                        end
                    end
                    iss_pkg::ISS_RX: if (scl_rise) begin
                        sh_r  <= {sh_r[6:0], sda_s};
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == iss_pkg::CNT_LAST) begin
                            dbuf_r   <= {sh_r[6:0], sda_s};
                            hcf_r    <= 1'b1;
                            ev_r     <= 1'b1;
                            ack_on_r <= 1'b0;
                            st_r     <= iss_pkg::ISS_ACKR;
                        end
                    end
                    iss_pkg::ISS_TX: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == iss_pkg::CNT_BYTE) begin
                                sda_oe_r <= 1'b0;                       // let master ack
                                st_r     <= iss_pkg::ISS_ACKT;
                            end else begin
                                sh_r     <= {sh_r[6:0], 1'b0};
                                sda_oe_r <= !sh_r[6];
                            end
                        end
                    end
                    iss_pkg::ISS_ACKT: begin
                        if (scl_rise) begin
                            ack_received_flag_r <= sda_s;
                            hcf_r  <= 1'b1;
                            ev_r   <= 1'b1;
                        end else if (scl_fall) begin
                            if (!ack_received_flag_r) begin
                                scl_oe_r <= 1'b1;
                                st_r     <= iss_pkg::ISS_HOLD;
                            end else begin
                                st_r <= iss_pkg::ISS_IGN;
                            end
                        end
                    end
                    iss_pkg::ISS_IDLE, iss_pkg::ISS_IGN: ;              // wait for start
                    default: st_r <= iss_pkg::ISS_IDLE;
                endcase
            end
        end
    end

    // interrupt gate; the timeout cause has no counter here and never fires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ev_r & irq_en_r;
        end
    end

    // drive levels are constant low: open drain by enable only
    assign scl_o      = 1'b0;
    assign sda_o      = 1'b0;
    assign scl_oe     = scl_oe_r;
    assign sda_oe     = sda_oe_r;
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign serial_irq = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_start_busy: assert property (start_det && active && !stop_det |=> hbb_r)
        else $error("start did not set busy");
    a_stop_free: assert property (stop_det && active |=> !hbb_r)
        else $error("stop did not clear busy");
    a_addr_ack: assert property (st_r == iss_pkg::ISS_ACKA && ack_on_r |-> sda_oe_r)
        else $error("address ack not driven");
    a_data_ack: assert property (st_r == iss_pkg::ISS_ACKR && ack_on_r |-> sda_oe_r == !ack_to_send_r)
        else $error("receive ack differs from ack_to_send");
    a_ignore_free: assert property (st_r == iss_pkg::ISS_IGN |-> !sda_oe_r)
        else $error("sda held while ignoring bus");
    a_sda_low_scl: assert property ($rose(sda_oe_r) |-> !scl_s)
        else $error("sda pulled while scl high");
    a_hold_scl: assert property (st_r == iss_pkg::ISS_HOLD && !tx_go && !rx_go && active
                                 && !stop_det && !start_det |=> scl_oe_r)
        else $error("scl not held while awaiting service");
    a_busy_hcf: assert property (st_r == iss_pkg::ISS_RX || st_r == iss_pkg::ISS_TX |-> !hcf_r)
        else $error("byte done high during transfer");
    a_match_irq: assert property ($rose(address_match_flag_r) && irq_en_r |=> irq_r ##1 !irq_r)
        else $error("match gave no single interrupt pulse");
    a_tx_msb: assert property (tx_go && st_r == iss_pkg::ISS_HOLD && active && !stop_det && !start_det
                               |=> sda_oe_r == !dbuf_r[7] && st_r == iss_pkg::ISS_TX)
        else $error("first transmit bit is not msb");
endmodule

// *** hdl/iss_pkg.sv ***
// constants and types shared by the i2c slave engine
package iss_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] OFS_MODE_CTRL   = 8'h00; // interface_mode_control
    localparam logic [7:0] OFS_STATUS_CTRL = 8'h04; // slave_status_control
    localparam logic [7:0] OFS_DATA_BUF    = 8'h08; // serial_data_buffer
    localparam logic [7:0] OFS_OWN_ADDR    = 8'h0C; // own_slave_address / spi_second_control
    localparam logic [7:0] OFS_IRQ_CTRL    = 8'h10; // serial_irq_enable and timeout_flag

    // interface_mode_control fields
    localparam int         MODE_MSB  = 7;           // interface_mode_select top bit
    localparam int         MODE_LSB  = 5;           // interface_mode_select low bit
    localparam int         DEB_MSB   = 3;           // debounce select, stored only
    localparam int         DEB_LSB   = 2;
    localparam int         EN_BIT    = 1;           // interface_enable
    localparam logic [2:0] MODE_I2C  = 3'h6;        // slave i2c mode select value
    localparam logic [2:0] MODE_RST  = 3'h7;        // mode field after reset

    // slave_status_control fields
    localparam int         HCF_BIT   = 7;           // byte_done_flag
    localparam int         ADDRESS_MATCH_FLAG_BIT  = 6;           // address_match_flag
    localparam int         HBB_BIT   = 5;           // bus_busy_flag
    localparam int         HTX_BIT   = 4;           // transmit_select
    localparam int         ACK_TO_SEND_BIT  = 3;           // ack_to_send
    localparam int         SRW_BIT   = 2;           // master_read_flag
    localparam int         WAKE_BIT  = 1;           // address match wake enable
    localparam int         ACK_RECEIVED_FLAG_BIT  = 0;           // ack_received_flag
    localparam logic       HCF_RST   = 1'h1;
    localparam logic       ACK_RECEIVED_FLAG_RST  = 1'h1;

    // irq control fields
    localparam int         IRQEN_BIT = 0;           // serial_irq_enable
    localparam int         TOF_BIT   = 1;           // timeout_flag

    // bit counting of a byte
    localparam logic [3:0] CNT_LAST  = 4'h7;        // rising edge of the eighth bit
    localparam logic [3:0] CNT_BYTE  = 4'h8;        // all eight bits clocked out
    localparam logic [7:0] BYTE_RST  = 8'h00;

    // byte engine states
    // nine states do not fit in three bits
    typedef enum logic [3:0] {
        ISS_IDLE, ISS_ADDR, ISS_ACKA, ISS_HOLD, ISS_RX, ISS_ACKR, ISS_TX, ISS_ACKT, ISS_IGN
    } iss_state_t;
endpackage

// *** hdl/iss_sync.sv ***
// two flip-flop synchroniser for pin inputs, one stage pair per bit
module iss_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // asynchronous levels in, synchronous levels out
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r; // first stage, read only by the second stage

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // idle bus is high, so both stages reset high
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r[i] <= 1'b1;
                    sync_o[i] <= 1'b1;
                end else begin
                    meta_r[i] <= async_i[i];
                    sync_o[i] <= meta_r[i];
                end
            end
        end
    endgenerate
endmodule

// *** tb/iss_bus_master_model.sv ***
// i2c bus master model driving the slave engine over open-drain lines
module iss_bus_master_model (
    // resolved bus lines
    input  wire logic scl,
    input  wire logic sda,
    // pull-down enables, high pulls the line low
    output logic      scl_oe,
    output logic      sda_oe
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam realtime Q = 31.25; // quarter of the 125 ns link period
    // idle bus: both lines released to the pull-ups
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // sda falls while scl is high; only this side makes a start
    task automatic start();
        #Q sda_oe = 1'b1;
        #Q scl_oe = 1'b1;
    endtask
    // data set while scl low, then any stretch by the slave is waited out
    task automatic bit_io(input logic b, output logic s);
        #Q sda_oe = !b;
        #Q scl_oe = 1'b0;
        wait (scl === 1'b1);
        #Q s = sda;
        #Q scl_oe = 1'b1;
    endtask
    // eight bits msb first, then the ninth ack clock
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask
    // stop frees the bus, also after a call nobody answered
    task automatic stop();
        #Q sda_oe = 1'b1;
        #Q scl_oe = 1'b0;
        wait (scl === 1'b1);
        #Q sda_oe = 1'b0;
        #Q;
    endtask
endmodule

// *** tb/iss_i2c_slave_bench.sv ***
// self-checking bench for the i2c slave engine and its registers
module iss_i2c_slave_bench;
    timeunit 1ns;
    timeprecision 10ps;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; $display("mismatch %s expected %h seen %h", n, e, g); end end
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, scl_o, sda_o, scl_oe, sda_oe, serial_irq;
    logic [7:0]  paddr, rx;
    logic [31:0] pwdata, prdata, q;
    logic        m_scl_oe, m_sda_oe, ack, err;
    int          fails, tests_run, irqs;
    // open-drain wires, pulled up unless someone pulls low
    wire logic scl_ln = !(scl_oe | m_scl_oe);
    wire logic sda_ln = !(sda_oe | m_sda_oe);
    iss_i2c_slave dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .scl_i(scl_ln), .scl_o, .scl_oe, .sda_i(sda_ln), .sda_o, .sda_oe, .serial_irq);
    iss_bus_master_model mdl (.scl(scl_ln), .sda(sda_ln), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // count interrupt pulses; they are not sticky
    always @(posedge pclk) if (serial_irq === 1'b1) irqs++;
    // slave may move sda only while scl is low
    always @(sda_oe) if (presetn === 1'b1) `CHK("sda_move", 1'b0, scl_ln)
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reset values, unmapped access, then mode, address, irq enable
    task automatic setup_regs();
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("status_rst", 32'h81, q)
        apb(0, iss_pkg::OFS_OWN_ADDR, 0); `CHK("addr_rst", 32'h00, q)
        apb(1, 8'h14, 32'h5A); `CHK("unmapped", 1'b1, err)
        apb(1, iss_pkg::OFS_MODE_CTRL, 32'hC2);
        apb(1, iss_pkg::OFS_OWN_ADDR, 32'hB5); // address 5A, free bit set
        apb(0, iss_pkg::OFS_OWN_ADDR, 0); `CHK("addr_rw", 32'hB5, q)
        apb(1, iss_pkg::OFS_IRQ_CTRL, 32'h01);
    endtask
    // master writes two bytes, the second refused by ack_to_send
    task automatic write_transfer();
        mdl.start();
        mdl.byte_io(8'hB4, 1'b1, rx, ack); `CHK("addr_ack", 1'b0, ack)
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("flags", 3'b110, {q[6], q[5], q[2]})
        `CHK("scl_held", 1'b1, scl_oe)
        `CHK("drive_low", 2'b00, {scl_o, sda_o})
        `CHK("irq_match", 1, irqs)
        apb(1, iss_pkg::OFS_STATUS_CTRL, 0); // receiver, acking
        apb(0, iss_pkg::OFS_DATA_BUF, 0); // dummy read frees scl
        @(posedge pclk);
        `CHK("scl_free", 1'b0, scl_oe)
        mdl.byte_io(8'hC3, 1'b1, rx, ack); `CHK("rx_ack", 1'b0, ack)
        apb(0, iss_pkg::OFS_DATA_BUF, 0); `CHK("rx_byte1", 32'hC3, q)
        apb(1, iss_pkg::OFS_STATUS_CTRL, 32'h08);
        mdl.byte_io(8'h3C, 1'b1, rx, ack); `CHK("rx_nack", 1'b1, ack)
        apb(0, iss_pkg::OFS_DATA_BUF, 0); `CHK("rx_byte2", 32'h3C, q)
        `CHK("irq_bytes", 3, irqs)
        mdl.stop();
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("busy_off", 1'b0, q[5])
    endtask
    // master reads two bytes, acking the first only
    task automatic read_transfer();
        mdl.start();
        mdl.byte_io(8'hB5, 1'b1, rx, ack); `CHK("addr_ack_rd", 1'b0, ack)
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("read_flag", 1'b1, q[2])
        apb(1, iss_pkg::OFS_STATUS_CTRL, 32'h10);
        apb(1, iss_pkg::OFS_DATA_BUF, 32'h96);
        mdl.byte_io(8'hFF, 1'b0, rx, ack); `CHK("tx_byte1", 8'h96, rx)
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("ack_seen", 1'b0, q[0])
        apb(1, iss_pkg::OFS_DATA_BUF, 32'h21);
        mdl.byte_io(8'hFF, 1'b1, rx, ack); `CHK("tx_byte2", 8'h21, rx)
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("nack_seen", 1'b1, q[0])
        `CHK("sda_free", 1'b0, sda_oe)
        mdl.stop();
    endtask
    // a foreign address gets no ack and no interrupt
    task automatic wrong_address();
        int n;
        n = irqs;
        mdl.start();
        mdl.byte_io(8'h22, 1'b1, rx, ack); `CHK("no_ack", 1'b1, ack)
        mdl.stop();
        `CHK("no_irq", n, irqs)
    endtask
    // a non-i2c mode stops the engine: flags to defaults, address kept
    task automatic mode_switch();
        apb(1, iss_pkg::OFS_MODE_CTRL, 32'hA2);
        apb(0, iss_pkg::OFS_STATUS_CTRL, 0); `CHK("flags_off", 32'h91, q)
        apb(0, iss_pkg::OFS_OWN_ADDR, 0); `CHK("addr_kept", 32'hB5, q)
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // reset for two cycles, then the scenarios in order
    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        {fails, tests_run, irqs} = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        setup_regs();
        write_transfer();
        read_transfer();
        wrong_address();
        mode_switch();
        report_and_stop();
    end
    // watchdog: the whole run needs well under 50 us
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule
